// [hdl/lmt_regs.svh]
// Purpose: register map, field positions and reset values of the line monitor block
// Assumes: byte address on the register bus is four times the register index
// Notes:   definitions only
`ifndef LMT_REGS_SVH
`define LMT_REGS_SVH

`define LMT_ADDR_W      10
`define LMT_IDX_THRESH  8'h2B
`define LMT_IDX_CTRL    8'h2C
`define LMT_IDX_GIE     8'h30
`define LMT_IDX_STAT    8'h31
`define LMT_IDX_MASK    8'h32
`define LMT_IDX_LEVEL   8'h33

`define LMT_CTRL_DIR    0
`define LMT_CTRL_IMASK  1
`define LMT_CTRL_SRC    2
`define LMT_CTRL_FLAG   3

`define LMT_EV_CROSS    0
`define LMT_EV_CUR      1
`define LMT_EV_VOLT     2
`define LMT_EV_W        3

`define LMT_RST_THRESH  8'h00
`define LMT_RST_CTRL    4'h0
`define LMT_RST_GIE     1'h0
`define LMT_RST_STAT    3'h0
`define LMT_RST_MASK    3'h0
`define LMT_RST_LEVEL   9'h000

`define LMT_RESP_OKAY   2'h0
`define LMT_RESP_SLVERR 2'h2

`endif

// [hdl/lmt_pkg.sv]
// Purpose: shared types of the line monitor block
// Assumes: lmt_regs.svh gives the address width
// Notes:   types only, constants live in the header
`include "lmt_regs.svh"

package lmt_pkg;

  // one measurement update: valid is a one-cycle strobe, value is two's complement
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } lmt_meas_t;

  // control register, packed so that bit 3 is the flag and bit 0 the direction
  typedef struct packed {
    logic flag;
    logic src;
    logic imask;
    logic dir;
  } lmt_ctrl_t;

  // one register write handed from the bus slave to the register file
  typedef struct packed {
    logic                   en;
    logic [`LMT_ADDR_W-1:0] addr;
    logic [31:0]            data;
    logic [3:0]             strb;
  } lmt_wr_t;

endpackage

// [hdl/lmt_axil_slave.sv]
// Purpose: AXI4-Lite slave front end for the line monitor register file
// Assumes: one write and one read in flight at most
// Notes:   write performed one cycle after both address and data are held
`timescale 1ns/1ps
`default_nettype none
`include "lmt_regs.svh"

module lmt_axil_slave (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // write channels
  input  wire logic [`LMT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // read channels
  input  wire logic [`LMT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // register file side
  output var  lmt_pkg::lmt_wr_t       wr,
  input  wire logic                   wr_ok,
  output var  logic [`LMT_ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ok
);

  logic                   awready_q, awready_d;
  logic                   wready_q,  wready_d;
  logic [`LMT_ADDR_W-1:0] awaddr_q,  awaddr_d;
  logic [31:0]            wdata_q,   wdata_d;
  logic [3:0]             wstrb_q,   wstrb_d;
  logic                   bvalid_q,  bvalid_d;
  logic [1:0]             bresp_q,   bresp_d;
  logic                   arready_q, arready_d;
  logic                   rvalid_q,  rvalid_d;
  logic [31:0]            rdata_q,   rdata_d;
  logic [1:0]             rresp_q,   rresp_d;
  logic                   do_wr;

  ////////////////////////////////////////////////////////////////////////////
  // write path: a held address and held data fire once no response is pending
  assign do_wr = !awready_q && !wready_q && !bvalid_q;
  assign wr    = '{en: do_wr, addr: awaddr_q, data: wdata_q, strb: wstrb_q};

  // read data comes straight from the decode of the offered address
  assign rd_addr = s_axi_araddr;

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && awready_q) begin
      awready_d = 1'h0;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      wready_d = 1'h0;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'h0;
    end
    if (do_wr) begin
      awready_d = 1'h1;
      wready_d  = 1'h1;
      bvalid_d  = 1'h1;
      bresp_d   = wr_ok ? `LMT_RESP_OKAY : `LMT_RESP_SLVERR;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'h0;
      rvalid_d  = 1'h1;
      rdata_d   = rd_ok ? rd_data : 32'h0000_0000;
      rresp_d   = rd_ok ? `LMT_RESP_OKAY : `LMT_RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'h0;
      arready_d = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'h1;
      wready_q  <= 1'h1;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'h0;
      bresp_q   <= `LMT_RESP_OKAY;
      arready_q <= 1'h1;
      rvalid_q  <= 1'h0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `LMT_RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

// [hdl/lmt_top.sv]
// Purpose: line current / line voltage threshold crossing interrupt block
// Assumes: measurement updates arrive as one-cycle strobes synchronous to aclk
// Notes:   registers on AXI4-Lite, byte address = 4 x register index
//
// How it works
// - an 8-bit writable threshold is the comparison level for crossings
// - source select 0 compares line current, 1 compares line voltage
// - direction 0 fires below threshold, 1 fires above, on absolute value
// - a crossing sets the flag at control bit 3; it reads 0 otherwise
// - the flag stays set until software writes 0 to it
// - pin asserts on a set flag only with mask and global enable set
// - with the crossing mask at 0 the pin never asserts
`timescale 1ns/1ps
`default_nettype none
`include "lmt_regs.svh"

module lmt_top (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write channels
  input  wire logic [`LMT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read channels
  input  wire logic [`LMT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // measurement updates
  input  wire lmt_pkg::lmt_meas_t     line_current_measure,
  input  wire lmt_pkg::lmt_meas_t     line_voltage_measure,
  // interrupt outputs
  output var  logic                   analog_out_irq_pin,
  output var  logic                   irq
);

  lmt_pkg::lmt_wr_t       wr;
  logic                   wr_ok;
  logic [`LMT_ADDR_W-1:0] rd_addr;
  logic [31:0]            rd_data;
  logic                   rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  lmt_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // nine bits so that the most negative code keeps its full magnitude
  function automatic logic [8:0] magnitude(input logic [7:0] v);
    magnitude = v[7] ? (9'h000 - {1'h1, v}) : {1'h0, v};
  endfunction

  function automatic logic [7:0] reg_index(input logic [`LMT_ADDR_W-1:0] a);
    reg_index = a[`LMT_ADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]          thresh_q, thresh_d;
  lmt_pkg::lmt_ctrl_t  ctrl_q,   ctrl_d;
  logic                gie_q,    gie_d;
  logic [`LMT_EV_W-1:0] stat_q,  stat_d;
  logic [`LMT_EV_W-1:0] mask_q,  mask_d;
  logic [8:0]          level_q,  level_d;
  logic                pin_q,    pin_d;
  logic                irq_q,    irq_d;

  lmt_pkg::lmt_meas_t  sel;
  logic [8:0]          cur_mag;
  logic [8:0]          volt_mag;
  logic [8:0]          sel_mag;
  logic [8:0]          thr9;
  logic                hit;
  logic                wr_lane;
  logic                wr_thr;
  logic                wr_ctrl;
  logic                wr_gie;
  logic                wr_stat;
  logic                wr_mask;
  logic [`LMT_EV_W-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // threshold comparison

  assign cur_mag  = magnitude(line_current_measure.value);
  assign volt_mag = magnitude(line_voltage_measure.value);
  assign sel      = ctrl_q.src ? line_voltage_measure : line_current_measure;
  assign sel_mag  = ctrl_q.src ? volt_mag : cur_mag;
  assign thr9     = {1'h0, thresh_q};
  // evaluated only on the strobe of the selected source, so one hit per update
  assign hit = sel.valid && (ctrl_q.dir ? (sel_mag > thr9) : (sel_mag < thr9));

  assign events = {line_voltage_measure.valid, line_current_measure.valid, hit};

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // written registers are one byte wide at most, only the low lane carries them
  assign wr_lane = wr.en && wr.strb[0];
  assign wr_thr  = wr_lane && (reg_index(wr.addr) == `LMT_IDX_THRESH);
  assign wr_ctrl = wr_lane && (reg_index(wr.addr) == `LMT_IDX_CTRL);
  assign wr_gie  = wr_lane && (reg_index(wr.addr) == `LMT_IDX_GIE);
  assign wr_stat = wr_lane && (reg_index(wr.addr) == `LMT_IDX_STAT);
  assign wr_mask = wr_lane && (reg_index(wr.addr) == `LMT_IDX_MASK);

  always_comb begin
    thresh_d = thresh_q;
    ctrl_d   = ctrl_q;
    gie_d    = gie_q;
    stat_d   = stat_q;
    mask_d   = mask_q;
    level_d  = level_q;
    if (wr_thr) begin
      thresh_d = wr.data[7:0];
    end
    if (wr_ctrl) begin
      ctrl_d.src   = wr.data[`LMT_CTRL_SRC];
      ctrl_d.imask = wr.data[`LMT_CTRL_IMASK];
      ctrl_d.dir   = wr.data[`LMT_CTRL_DIR];
      // writing 1 to the flag has no effect; only a 0 clears it
      if (!wr.data[`LMT_CTRL_FLAG]) begin
        ctrl_d.flag = 1'h0;
      end
    end
    // a crossing in the clearing cycle wins over the clear
    if (hit) begin
      ctrl_d.flag = 1'h1;
    end
    if (wr_gie) begin
      gie_d = wr.data[0];
    end
    if (wr_stat) begin
      stat_d = stat_q & ~wr.data[`LMT_EV_W-1:0];
    end
    stat_d = stat_d | events;
    if (wr_mask) begin
      mask_d = wr.data[`LMT_EV_W-1:0];
    end
    if (sel.valid) begin
      level_d = sel_mag;
    end
    pin_d = ctrl_d.flag && ctrl_d.imask && gie_d;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh_q <= `LMT_RST_THRESH;
      ctrl_q   <= `LMT_RST_CTRL;
      gie_q    <= `LMT_RST_GIE;
      stat_q   <= `LMT_RST_STAT;
      mask_q   <= `LMT_RST_MASK;
      level_q  <= `LMT_RST_LEVEL;
      pin_q    <= 1'h0;
      irq_q    <= 1'h0;
    end else begin
      thresh_q <= thresh_d;
      ctrl_q   <= ctrl_d;
      gie_q    <= gie_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      level_q  <= level_d;
      pin_q    <= pin_d;
      irq_q    <= irq_d;
    end
  end

  assign analog_out_irq_pin = pin_q;
  assign irq                = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // register reads, reserved bits read zero

  assign wr_ok = (reg_index(wr.addr) inside {`LMT_IDX_THRESH, `LMT_IDX_CTRL, `LMT_IDX_GIE,
                                             `LMT_IDX_STAT, `LMT_IDX_MASK, `LMT_IDX_LEVEL});

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'h1;
    case (reg_index(rd_addr))
      `LMT_IDX_THRESH: rd_data[7:0]           = thresh_q;
      `LMT_IDX_CTRL:   rd_data[3:0]           = ctrl_q;
      `LMT_IDX_GIE:    rd_data[0]             = gie_q;
      `LMT_IDX_STAT:   rd_data[`LMT_EV_W-1:0] = stat_q;
      `LMT_IDX_MASK:   rd_data[`LMT_EV_W-1:0] = mask_q;
      `LMT_IDX_LEVEL:  rd_data[8:0]           = level_q;
      default:         rd_ok                  = 1'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence flag_clear_s;
    wr_ctrl && !wr.data[`LMT_CTRL_FLAG] && !hit;
  endsequence

  // pin drops at the same edge as the flag; a later crossing may raise both again
  sequence flag_low_s;
    ##1 (!ctrl_q.flag && !analog_out_irq_pin);
  endsequence

  thresh_load_a: assert property (wr_thr |=> thresh_q == $past(wr.data[7:0]))
    else $error("threshold not loaded from write");

  src_current_ignored_a: assert property (
    ctrl_q.src && !ctrl_q.flag && line_current_measure.valid
    && !line_voltage_measure.valid |=> !ctrl_q.flag)
    else $error("current update raised flag while voltage selected");

  dir_below_a: assert property (
    !ctrl_q.dir && sel.valid && (sel_mag < thr9) |=> ctrl_q.flag)
    else $error("below-threshold update did not set flag");

  dir_above_quiet_a: assert property (
    ctrl_q.dir && !ctrl_q.flag && !(sel.valid && sel_mag > thr9) |=> !ctrl_q.flag)
    else $error("flag set without rising above threshold");

  flag_cause_a: assert property ($rose(ctrl_q.flag) |-> $past(hit) && stat_q[`LMT_EV_CROSS])
    else $error("flag rose without a crossing");

  flag_sticky_a: assert property (
    ctrl_q.flag && !(wr_ctrl && !wr.data[`LMT_CTRL_FLAG]) |=> ctrl_q.flag)
    else $error("flag dropped without a clearing write");

  flag_clear_a: assert property (flag_clear_s |-> flag_low_s)
    else $error("clearing write did not drop flag and pin");

  pin_raise_a: assert property (
    $rose(ctrl_q.flag) && ctrl_q.imask && gie_q |-> analog_out_irq_pin)
    else $error("pin not raised with flag, mask and enable set");

  pin_gate_a: assert property (analog_out_irq_pin |-> ctrl_q.flag && gie_q)
    else $error("pin high without flag and global enable");

  pin_mask_a: assert property (!ctrl_q.imask |-> !analog_out_irq_pin)
    else $error("pin high with crossing mask clear");

  once_update_a: assert property ($rose(ctrl_q.flag) |-> $past(sel.valid))
    else $error("flag set without a selected update");

endmodule

`default_nettype wire

// [dv/lmt_host_model.sv]
// Purpose: host processor model, master on the register bus
// Assumes: one clock, requests launched just after a rising edge
// Notes:   one write or one read at a time; waits are cut only by the bench timeout
`timescale 1ns/1ps
`default_nettype none
`include "lmt_regs.svh"

module lmt_host_model (
  // clock
  input  wire logic                   aclk,
  // write channels
  output var  logic [`LMT_ADDR_W-1:0] awaddr,
  output var  logic                   awvalid,
  input  wire logic                   awready,
  output var  logic [31:0]            wdata,
  output var  logic [3:0]             wstrb,
  output var  logic                   wvalid,
  input  wire logic                   wready,
  input  wire logic [1:0]             bresp,
  input  wire logic                   bvalid,
  output var  logic                   bready,
  // read channels
  output var  logic [`LMT_ADDR_W-1:0] araddr,
  output var  logic                   arvalid,
  input  wire logic                   arready,
  input  wire logic [31:0]            rdata,
  input  wire logic [1:0]             rresp,
  input  wire logic                   rvalid,
  output var  logic                   rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // random idle gap makes the host sometimes slow to issue
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    repeat ($urandom_range(1, 3)) @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    repeat ($urandom_range(1, 3)) @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // software clears the crossing flag by writing 0 to it
  task automatic clear_flag(input logic [2:0] keep, output logic [1:0] r);
    wr(`LMT_IDX_CTRL, {5'h00, keep}, r);
  endtask
endmodule
`default_nettype wire

// [dv/lmt_top_tb_top.sv]
// Purpose: self-checking bench of the line monitor threshold block
// Assumes: host model drives the register bus, bench drives measurements
// Notes:   seeded random thresholds and samples with corner cases first
`timescale 1ns/1ps
`default_nettype none
`include "lmt_regs.svh"

module lmt_top_tb_top;
  logic                   aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready, pin, irq;
  logic [`LMT_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  lmt_pkg::lmt_meas_t     cur, vol;
  int                     fails, samples_checked, cycles;

  lmt_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_current_measure(cur), .line_voltage_measure(vol),
    .analog_out_irq_pin(pin), .irq(irq)
  );

  lmt_host_model h (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] mag(input logic [7:0] v);
    return v[7] ? (9'h000 - {v[7], v}) : {1'b0, v};
  endfunction

  // strict compare: an equal magnitude never fires
  function automatic logic hit(input logic [7:0] thr, input logic [7:0] v, input logic dir);
    return dir ? (mag(v) > {1'b0, thr}) : (mag(v) < {1'b0, thr});
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t output got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t response got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle update strobe; vld low only shows a value
  task automatic strobe(input logic src, input logic [7:0] v, input logic vld);
    @(posedge aclk);
    if (src) begin
      vol <= {vld, v};
    end else begin
      cur <= {vld, v};
    end
    @(posedge aclk);
    cur <= {1'b0, 8'($urandom)};
    vol <= {1'b0, 8'($urandom)};
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // run is under 1600 cycles; this ceiling only catches a hang
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] %0t run hung", $time);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  thr, v;
    logic [7:0]  ridx [6];
    logic        dir, src, e;
    {aresetn, fails, samples_checked, cycles} = '0;
    cur = '0;
    vol = '0;
    void'($urandom(32'h0BD0));
    ridx = '{`LMT_IDX_THRESH, `LMT_IDX_CTRL, `LMT_IDX_GIE, `LMT_IDX_STAT, `LMT_IDX_MASK,
             `LMT_IDX_LEVEL};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, unmapped place, threshold readback
    foreach (ridx[k]) begin
      h.rd(ridx[k], d, r);
      chk_word(d, 32'h00000000);
    end
    h.rd(8'h00, d, r);
    chk_resp(r, `LMT_RESP_SLVERR);
    h.wr(8'h00, 8'h5A, r);
    chk_resp(r, `LMT_RESP_SLVERR);
    h.wr(`LMT_IDX_THRESH, 8'hA5, r);
    h.rd(`LMT_IDX_THRESH, d, r);
    chk_word(d, 32'h000000A5);
    $display("test registers done");
    // random crossings, first three are corner cases
    h.wr(`LMT_IDX_GIE, 8'h01, r);
    for (int i = 0; i < 40; i++) begin
      thr = 8'($urandom);
      v   = 8'($urandom);
      dir = 1'($urandom);
      src = 1'($urandom);
      if (i == 0) begin
        thr = 8'h7F;
        v   = 8'h80;
      end
      if (i == 1) v = thr;
      if (i == 2) v = 8'h00 - thr;
      h.wr(`LMT_IDX_THRESH, thr, r);
      h.wr(`LMT_IDX_CTRL, {5'h00, src, 1'b1, dir}, r);
      strobe(!src, dir ? 8'h80 : 8'h00, 1'b1);
      strobe(src, v, 1'b0);
      chk_bit(pin, 1'b0);
      strobe(src, v, 1'b1);
      e = hit(thr, v, dir);
      chk_bit(pin, e);
      h.rd(`LMT_IDX_CTRL, d, r);
      chk_word(d, {28'h0000000, e, src, 1'b1, dir});
      h.rd(`LMT_IDX_LEVEL, d, r);
      chk_word(d, {23'h000000, mag(v)});
      h.clear_flag({src, 1'b1, dir}, r);
      chk_bit(pin, 1'b0);
    end
    $display("test crossings done");
    // mask and global enable gating, sticky flag
    h.wr(`LMT_IDX_THRESH, 8'h10, r);
    h.wr(`LMT_IDX_CTRL, 8'h00, r);
    strobe(1'b0, 8'h01, 1'b1);
    chk_bit(pin, 1'b0);
    h.rd(`LMT_IDX_CTRL, d, r);
    chk_word(d, 32'h00000008);
    h.wr(`LMT_IDX_GIE, 8'h00, r);
    h.wr(`LMT_IDX_CTRL, 8'h0A, r);
    chk_bit(pin, 1'b0);
    h.wr(`LMT_IDX_GIE, 8'h01, r);
    chk_bit(pin, 1'b1);
    h.wr(`LMT_IDX_CTRL, 8'h0A, r);
    chk_bit(pin, 1'b1);
    h.clear_flag(3'b010, r);
    chk_bit(pin, 1'b0);
    $display("test gating done");
    // event status, mask and level interrupt; earlier updates left status bits set
    h.wr(`LMT_IDX_STAT, 8'h07, r);
    h.wr(`LMT_IDX_MASK, 8'h01, r);
    chk_bit(irq, 1'b0);
    strobe(1'b0, 8'h01, 1'b1);
    chk_bit(irq, 1'b1);
    h.rd(`LMT_IDX_STAT, d, r);
    chk_word(d, 32'h00000003);
    h.wr(`LMT_IDX_STAT, 8'h01, r);
    chk_bit(irq, 1'b0);
    h.wr(`LMT_IDX_MASK, 8'h02, r);
    chk_bit(irq, 1'b1);
    h.wr(`LMT_IDX_MASK, 8'h00, r);
    chk_bit(irq, 1'b0);
    $display("test event interrupt done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
